// file: tte_trap_entry.v
// Trap entry sequencer: accepts trap requests, saves context, loads state,
// and redirects fetch to the handler.
// Assumes the pipeline stalls while trap_ready is low and holds request data.
`timescale 1ns/10ps
`default_nettype none
`include "tte_defs.vh"

module tte_trap_entry #(
  parameter ADDR_W = 32
) (
  input wire mclk,
  input wire reset_n,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  input wire init_protection_window,
  // Hardware trap source (sync or async)
  input wire trap_req,
  input wire trap_async,
  input wire [`TTE_CLASS_W-1:0] trap_class_index,
  input wire [`TTE_IDENT_W-1:0] trap_ident_number,
  input wire free_context_underflow_trap,
  input wire free_context_depletion_trap,
  // Software trap sources
  input wire system_call_instr,
  input wire [`TTE_IDENT_W-1:0] system_call_imm,
  input wire trap_on_overflow_instr,
  input wire trap_on_sticky_overflow_instr,
  // Program counters from the pipeline
  input wire [ADDR_W-1:0] trap_pc,
  input wire [ADDR_W-1:0] trap_next_pc,
  output wire trap_ready,
  output reg pipe_flush,
  // Upper context save handshake
  output reg ctx_save_req,
  input wire ctx_save_ack,
  // Current status state
  input wire interrupt_stack_flag,
  input wire global_irq_enable,
  input wire [7:0] current_cpu_priority,
  // Register file writes
  output reg d15_we,
  output reg [31:0] d15_data,
  output reg a11_we,
  output reg [ADDR_W-1:0] a11_data,
  output reg a10_we,
  output reg [ADDR_W-1:0] a10_data,
  // Status word writes
  output reg status_we,
  output reg status_stack_flag,
  output reg [1:0] access_privilege_field,
  output reg [1:0] protection_set_select,
  output reg depth_we,
  output reg [6:0] call_depth_counter,
  output reg call_depth_count_enable,
  output reg global_reg_write_permit,
  // Interrupt control writes; priority field is never driven
  output reg irq_enable_we,
  output reg irq_enable_value,
  output reg saved_ctx_we,
  output reg saved_irq_enable,
  output reg [7:0] saved_cpu_priority,
  // Fetch redirect
  output reg fetch_valid,
  output reg [ADDR_W-1:0] fetch_addr
);

  localparam [3:0] S_IDLE = 4'h1;
  localparam [3:0] S_SAVE = 4'h2;
  localparam [3:0] S_LOAD = 4'h4;
  localparam [3:0] S_FETCH = 4'h8;

  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg [ADDR_W-1:0] vec_base_reg;
  reg [ADDR_W-1:0] stack_ptr_reg;
  reg [`TTE_CLASS_W-1:0] class_reg;
  reg [`TTE_IDENT_W-1:0] ident_reg;
  reg [ADDR_W-1:0] ret_addr_reg;
  reg underflow_reg;
  reg async_reg;
  reg [ADDR_W-1:0] entry_reg;
  reg refused_reg;

  wire [ADDR_W-1:0] entry_addr;
  wire any_req;
  wire accept;
  wire apb_wr;
  wire apb_rd;
  wire hit;
  reg [`TTE_CLASS_W-1:0] sel_class;
  reg [`TTE_IDENT_W-1:0] sel_ident;
  reg [ADDR_W-1:0] sel_ra;
  reg sel_underflow;
  reg sel_async;

  // Vector address former
  tte_entry_addr #(
    .ADDR_W(ADDR_W)
  ) tte_entry_addr_inst (
    .vec_base(vec_base_reg),
    .class_index(class_reg),
    .entry_addr(entry_addr)
  );

  // Requests wait while a sequence runs; pipeline is stalled meanwhile
  assign any_req = trap_req | system_call_instr | trap_on_overflow_instr |
                   trap_on_sticky_overflow_instr;
  assign trap_ready = (state_reg == S_IDLE);
  assign accept = trap_ready & any_req;

  // Source selection; hardware traps win over software ones
  always @* begin
    sel_class = trap_class_index;
    sel_ident = trap_ident_number;
    sel_ra = trap_pc;
    sel_underflow = 1'b0;
    sel_async = 1'b0;
    if (trap_req) begin
      sel_underflow = free_context_underflow_trap;
      sel_async = trap_async;
      // Async and depletion traps resume at the next instruction
      if (trap_async | free_context_depletion_trap) begin
        sel_ra = trap_next_pc;
      end
    end else if (system_call_instr) begin
      sel_class = `TTE_CLASS_CALL;
      sel_ident = system_call_imm;
      sel_ra = trap_next_pc;
    end else if (trap_on_overflow_instr) begin
      sel_class = `TTE_CLASS_ASSERT;
      sel_ident = `TTE_IDENT_OVERFLOW;
    end else begin
      sel_class = `TTE_CLASS_ASSERT;
      sel_ident = `TTE_IDENT_STICKY;
    end
  end

  // Next state of the entry sequence
  always @* begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE: begin
        if (accept) begin
          state_next = sel_underflow ? S_LOAD : S_SAVE;
        end
      end
      S_SAVE: begin
        // Handler may not start before the save completes
        if (ctx_save_ack) begin
          state_next = S_LOAD;
        end
      end
      S_LOAD: begin
        state_next = S_FETCH;
      end
      S_FETCH: begin
        state_next = S_IDLE;
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  // State and captured trap identifier
  always @(posedge mclk) begin
    if (!reset_n) begin
      state_reg <= S_IDLE;
      class_reg <= {`TTE_CLASS_W{1'b0}};
      ident_reg <= {`TTE_IDENT_W{1'b0}};
      ret_addr_reg <= {ADDR_W{1'b0}};
      underflow_reg <= 1'b0;
      async_reg <= 1'b0;
      pipe_flush <= 1'b0;
    end else begin
      state_reg <= state_next;
      pipe_flush <= accept;
      if (accept) begin
        class_reg <= sel_class;
        ident_reg <= sel_ident;
        ret_addr_reg <= sel_ra;
        underflow_reg <= sel_underflow;
        async_reg <= sel_async;
      end
    end
  end

  // Context save request held until acknowledged
  always @(posedge mclk) begin
    if (!reset_n) begin
      ctx_save_req <= 1'b0;
    end else if (accept && !sel_underflow) begin
      ctx_save_req <= 1'b1;
    end else if (ctx_save_ack) begin
      ctx_save_req <= 1'b0;
    end
  end

  // State loads, one-cycle write strobes issued from the load state
  always @(posedge mclk) begin
    if (!reset_n) begin
      d15_we <= 1'b0;
      d15_data <= 32'h00000000;
      a11_we <= 1'b0;
      a11_data <= {ADDR_W{1'b0}};
      a10_we <= 1'b0;
      a10_data <= {ADDR_W{1'b0}};
      status_we <= 1'b0;
      status_stack_flag <= 1'b0;
      access_privilege_field <= 2'h0;
      protection_set_select <= 2'h0;
      depth_we <= 1'b0;
      call_depth_counter <= 7'h00;
      call_depth_count_enable <= 1'b0;
      global_reg_write_permit <= 1'b0;
      irq_enable_we <= 1'b0;
      irq_enable_value <= 1'b0;
      saved_ctx_we <= 1'b0;
      saved_irq_enable <= 1'b0;
      saved_cpu_priority <= 8'h00;
    end else begin
      d15_we <= 1'b0;
      a11_we <= 1'b0;
      a10_we <= 1'b0;
      status_we <= 1'b0;
      depth_we <= 1'b0;
      irq_enable_we <= 1'b0;
      saved_ctx_we <= 1'b0;
      if (state_reg == S_LOAD) begin
        d15_we <= 1'b1;
        d15_data <= {{(32-`TTE_IDENT_W){1'b0}}, ident_reg};
        // Underflow guarantees no return address
        a11_we <= ~underflow_reg;
        a11_data <= ret_addr_reg;
        a10_we <= ~interrupt_stack_flag;
        a10_data <= stack_ptr_reg;
        status_we <= 1'b1;
        status_stack_flag <= 1'b1;
        access_privilege_field <= `TTE_PRIV_SUPERVISOR;
        protection_set_select <= `TTE_PROT_SET_ZERO;
        depth_we <= ~underflow_reg;
        call_depth_counter <= `TTE_DEPTH_CLEAR;
        call_depth_count_enable <= 1'b1;
        global_reg_write_permit <= 1'b0;
        // Unmaskable entry; priority is left as it stands
        irq_enable_we <= 1'b1;
        irq_enable_value <= 1'b0;
        saved_ctx_we <= ~underflow_reg;
        saved_irq_enable <= global_irq_enable;
        saved_cpu_priority <= current_cpu_priority;
      end
    end
  end

  // Fetch redirect to the handler slot
  always @(posedge mclk) begin
    if (!reset_n) begin
      fetch_valid <= 1'b0;
      fetch_addr <= {ADDR_W{1'b0}};
      entry_reg <= {ADDR_W{1'b0}};
    end else begin
      fetch_valid <= (state_reg == S_FETCH);
      if (state_reg == S_FETCH) begin
        fetch_addr <= entry_addr;
        entry_reg <= entry_addr;
      end
    end
  end

  // APB decode; zero wait states
  assign apb_wr = psel & penable & pwrite;
  assign apb_rd = psel & ~pwrite;
  assign hit = (paddr == `TTE_OFF_VEC_BASE) ||
               (paddr == `TTE_OFF_STACK_PTR) ||
               (paddr == `TTE_OFF_STATUS) || (paddr == `TTE_OFF_RET_ADDR) ||
               (paddr == `TTE_OFF_ENTRY);
  assign pready = 1'b1;
  // Unmapped, or a refused base write, answers with an error
  assign pslverr = psel & penable & (~hit | (pwrite &
                   (paddr == `TTE_OFF_VEC_BASE) & ~init_protection_window));

  // Software registers
  always @(posedge mclk) begin
    if (!reset_n) begin
      vec_base_reg <= `TTE_RST_VEC_BASE;
      stack_ptr_reg <= `TTE_RST_STACK_PTR;
      refused_reg <= 1'b0;
    end else begin
      if (apb_wr && paddr == `TTE_OFF_VEC_BASE) begin
        if (init_protection_window) begin
          vec_base_reg <= {pwdata[ADDR_W-1:1], 1'b0};
        end else begin
          refused_reg <= 1'b1;
        end
      end
      // Stack pointer write with window closed is dropped without error
      if (apb_wr && paddr == `TTE_OFF_STACK_PTR &&
          init_protection_window) begin
        stack_ptr_reg <= pwdata[ADDR_W-1:0];
      end
      // Read of status clears the sticky refusal flag; a new refusal wins
      if (psel && penable && !pwrite && paddr == `TTE_OFF_STATUS &&
          !(apb_wr && paddr == `TTE_OFF_VEC_BASE)) begin
        refused_reg <= 1'b0;
      end
    end
  end

  // Read data, registered in the setup cycle
  always @(posedge mclk) begin
    if (!reset_n) begin
      prdata <= 32'h00000000;
    end else if (apb_rd && !penable) begin
      case (paddr)
        `TTE_OFF_VEC_BASE: prdata <= vec_base_reg;
        `TTE_OFF_STACK_PTR: prdata <= stack_ptr_reg;
        `TTE_OFF_STATUS: prdata <= {17'h0, refused_reg, async_reg,
                                    underflow_reg, ~trap_ready, class_reg,
                                    ident_reg};
        `TTE_OFF_RET_ADDR: prdata <= ret_addr_reg;
        `TTE_OFF_ENTRY: prdata <= entry_reg;
        default: prdata <= 32'h00000000;
      endcase
    end
  end

endmodule // tte_trap_entry

`default_nettype wire

// file: tte_defs.vh
// Constants for the trap entry unit: APB offsets, field codes, reset values.
// Assumes a 32-bit APB register port and a single core clock.
`ifndef TTE_DEFS_VH
`define TTE_DEFS_VH

// APB register byte offsets
`define TTE_OFF_VEC_BASE 12'h000
`define TTE_OFF_STACK_PTR 12'h004
`define TTE_OFF_STATUS 12'h008
`define TTE_OFF_RET_ADDR 12'h00c
`define TTE_OFF_ENTRY 12'h010

// Reset values
`define TTE_RST_VEC_BASE 32'h00000000
`define TTE_RST_STACK_PTR 32'h00000000

// Widths and geometry
`define TTE_CLASS_W 3
`define TTE_IDENT_W 8
`define TTE_VEC_SHIFT 5

// Fixed classes and idents
`define TTE_CLASS_ASSERT 3'h5
`define TTE_CLASS_CALL 3'h6
`define TTE_IDENT_OVERFLOW 8'h01
`define TTE_IDENT_STICKY 8'h02

// Status word values written on entry
`define TTE_PRIV_SUPERVISOR 2'h2
`define TTE_PROT_SET_ZERO 2'h0
`define TTE_DEPTH_CLEAR 7'h00

`endif

// file: tte_entry_addr.v
// Handler entry address former for the trap entry unit.
// Assumes the vector base already has bit 0 cleared.
`timescale 1ns/10ps
`default_nettype none
`include "tte_defs.vh"

module tte_entry_addr #(
  parameter ADDR_W = 32
) (
  input wire [ADDR_W-1:0] vec_base,
  input wire [`TTE_CLASS_W-1:0] class_index,
  output wire [ADDR_W-1:0] entry_addr
);

  wire [ADDR_W-1:0] class_ext;
  wire [ADDR_W-1:0] class_shift;

  // Plain OR, no add: base bits 7..5 must be zero for distinct slots
  assign class_ext = {{(ADDR_W-`TTE_CLASS_W){1'b0}}, class_index};
  assign class_shift = class_ext << `TTE_VEC_SHIFT;
  assign entry_addr = class_shift | vec_base;

endmodule // tte_entry_addr

`default_nettype wire

// file: tte_chk.sv
// Checker for the trap entry unit, watching top-level ports only.
// Assumes one core clock and the synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module tte_chk (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic trap_req,
  input wire logic trap_ready,
  input wire logic free_context_underflow_trap,
  input wire logic pipe_flush,
  input wire logic ctx_save_req,
  input wire logic ctx_save_ack,
  input wire logic status_we,
  input wire logic status_stack_flag,
  input wire logic [1:0] access_privilege_field,
  input wire logic [1:0] protection_set_select,
  input wire logic depth_we,
  input wire logic [6:0] call_depth_counter,
  input wire logic call_depth_count_enable,
  input wire logic global_reg_write_permit,
  input wire logic irq_enable_we,
  input wire logic irq_enable_value,
  input wire logic saved_ctx_we,
  input wire logic a11_we,
  input wire logic d15_we,
  input wire logic a10_we,
  input wire logic fetch_valid,
  input wire logic [31:0] fetch_addr
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Full entry writes every strobe but a10_we at once; underflow skips the saves
  sequence full_strobes;
    status_we && depth_we && saved_ctx_we && a11_we && d15_we &&
    irq_enable_we;
  endsequence
  sequence short_strobes;
    status_we && d15_we && irq_enable_we && !depth_we && !saved_ctx_we &&
    !a11_we;
  endsequence
  take_flush_a: assert property (trap_req && trap_ready |=> pipe_flush)
    else $error("flush missing after take");
  flush_pulse_a: assert property (pipe_flush |=> !pipe_flush)
    else $error("flush longer than one cycle");
  normal_order_a: assert property (ctx_save_req && ctx_save_ack
    |=> !ctx_save_req ##1 full_strobes ##1 fetch_valid)
    else $error("normal entry out of order");
  underflow_path_a: assert property (trap_req && trap_ready
    && free_context_underflow_trap
    |=> !ctx_save_req ##1 short_strobes ##1 fetch_valid)
    else $error("underflow entry wrong");
  save_first_a: assert property (ctx_save_req |->
    !status_we && !fetch_valid)
    else $error("state written before save");
  super_mode_a: assert property (status_we |->
    status_stack_flag && access_privilege_field == 2'h2
    && protection_set_select == 2'h0)
    else $error("status word values wrong");
  depth_clear_a: assert property (depth_we |->
    call_depth_counter == 7'h00 && call_depth_count_enable
    && !global_reg_write_permit)
    else $error("call depth fields wrong");
  irq_off_a: assert property (irq_enable_we |->
    !irq_enable_value ##1 fetch_valid)
    else $error("enable not cleared before fetch");
  stack_load_a: assert property (a10_we |-> status_we)
    else $error("stack load without flag set");
  fetch_align_a: assert property (fetch_valid |-> !fetch_addr[0]
    && $past(status_we))
    else $error("fetch odd or early");
endmodule // tte_chk
`default_nettype wire

// file: tte_ctx_model.sv
// Upper context store responder on the far side of the save handshake.
// Assumes ctx_save_req is held until the ack has been seen.
`timescale 1ns/10ps
`default_nettype none
module tte_ctx_model (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic slow,
  input wire logic ctx_save_req,
  output logic ctx_save_ack
);
  logic [2:0] wait_reg;
  // Slow mode stretches the save so the sequencer must really wait
  always_ff @(posedge mclk) begin
    if (!reset_n || !ctx_save_req || ctx_save_ack) begin
      wait_reg <= 3'h0;
      ctx_save_ack <= 1'b0;
    end else begin
      wait_reg <= wait_reg + 3'h1;
      ctx_save_ack <= wait_reg == (slow ? 3'h4 : 3'h0);
    end
  end
endmodule // tte_ctx_model
`default_nettype wire

// file: tte_tb.sv
// Testbench for the trap entry unit: APB set-up, then a run of traps.
// Assumes the context store model and the bound port checker.
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic mclk, reset_n, psel, penable, pwrite, pready, pslverr, e, slow;
  logic init_protection_window, trap_req, trap_async, trap_ready;
  logic free_context_underflow_trap, free_context_depletion_trap;
  logic system_call_instr, trap_on_overflow_instr, pipe_flush;
  logic trap_on_sticky_overflow_instr, ctx_save_req, ctx_save_ack;
  logic interrupt_stack_flag, global_irq_enable, d15_we, a11_we, a10_we;
  logic status_we, status_stack_flag, depth_we, call_depth_count_enable;
  logic global_reg_write_permit, irq_enable_we, irq_enable_value;
  logic saved_ctx_we, saved_irq_enable, fetch_valid;
  logic [1:0] access_privilege_field, protection_set_select;
  logic [2:0] trap_class_index;
  logic [6:0] call_depth_counter;
  logic [7:0] trap_ident_number, system_call_imm;
  logic [7:0] current_cpu_priority, saved_cpu_priority;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, trap_pc, trap_next_pc, d15_data, r;
  logic [31:0] a11_data, a10_data, fetch_addr;
  int mismatches, total_checks, cycles;
  tte_trap_entry tte_trap_entry_inst (.*);
  tte_ctx_model tte_ctx_model_inst (.*);
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, x);
    total_checks++;
    if (s !== x) begin
      mismatches++;
      $display("BAD %s exp %h seen %h", n, x, s);
    end
  endtask
  // Hang guard, well above the length of the whole sequence
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      stop_test;
    end
  end
  // One APB transfer; result left in r and e
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // k: 0 hardware, 1 system call, 2 overflow, 3 sticky overflow
  task automatic trap(input logic [1:0] k, input logic [2:0] c,
      input logic [7:0] id, input logic as, un, dp, isf);
    logic [2:0] ec;
    logic [7:0] ei;
    logic [31:0] ea, g11, g10, g15, gf;
    logic s11, s10, sf;
    ec = k == 0 ? c : (k == 1 ? 3'h6 : 3'h5);
    ei = k < 2 ? id : {6'h00, k - 2'h1};
    // Calls, async and depletion resume after; other sync traps re-run
    ea = (k == 1 || (k == 0 && (as || dp))) ? trap_next_pc : trap_pc;
    {s11, s10, sf} = 3'h0;
    @(posedge mclk);
    trap_req <= k == 0;
    trap_class_index <= c;
    trap_ident_number <= id;
    trap_async <= as;
    free_context_underflow_trap <= un;
    free_context_depletion_trap <= dp;
    system_call_instr <= k == 1;
    system_call_imm <= id;
    trap_on_overflow_instr <= k == 2;
    trap_on_sticky_overflow_instr <= k == 3;
    interrupt_stack_flag <= isf;
    global_irq_enable <= !as;
    slow <= ~slow;
    @(posedge mclk);
    chk("ready", trap_ready, 1);
    trap_req <= 1'b0;
    system_call_instr <= 1'b0;
    trap_on_overflow_instr <= 1'b0;
    trap_on_sticky_overflow_instr <= 1'b0;
    for (int i = 0; i < 16 && !sf; i++) begin
      @(posedge mclk);
      #1;
      if (d15_we === 1'b1) g15 = d15_data;
      if (a11_we === 1'b1) {s11, g11} = {1'b1, a11_data};
      if (a10_we === 1'b1) {s10, g10} = {1'b1, a10_data};
      if (fetch_valid === 1'b1) {sf, gf} = {1'b1, fetch_addr};
    end
    chk("fetch", sf, 1);
    chk("entry", gf, 32'h00001000 | {ec, 5'h00});
    chk("d15", g15, {24'h000000, ei});
    chk("a10 load", s10, !isf);
    if (!isf) chk("a10", g10, 32'h80000100);
    if (un) chk("a11 skip", s11, 0);
    if (!un) chk("a11", g11, ea);
    if (!un) chk("prio", saved_cpu_priority, 8'h5a);
    if (!un) chk("saved enable", saved_irq_enable, !as);
  endtask
  initial begin
    {reset_n, psel, penable, pwrite, paddr, pwdata, trap_req, trap_async,
      trap_class_index, trap_ident_number, free_context_underflow_trap,
      free_context_depletion_trap, system_call_instr, system_call_imm,
      trap_on_overflow_instr, trap_on_sticky_overflow_instr,
      interrupt_stack_flag, slow} = '0;
    {mismatches, total_checks, cycles} = '0;
    global_irq_enable = 1'b1;
    current_cpu_priority = 8'h5a;
    init_protection_window = 1'b1;
    trap_pc = 32'h00004440;
    trap_next_pc = 32'h00004444;
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    apb(1'b1, 12'h000, 32'h00001001);
    apb(1'b0, 12'h000, 32'h0);
    chk("base", r, 32'h00001000);
    apb(1'b1, 12'h004, 32'h80000100);
    init_protection_window <= 1'b0;
    apb(1'b1, 12'h000, 32'h00002000);
    chk("refused", e, 1);
    apb(1'b0, 12'h000, 32'h0);
    chk("kept", r, 32'h00001000);
    apb(1'b0, 12'h008, 32'h0);
    chk("refused flag", r, 32'h00004000);
    apb(1'b0, 12'h008, 32'h0);
    chk("flag cleared", r, 32'h00000000);
    apb(1'b1, 12'h004, 32'h00000200);
    chk("stack quiet", e, 0);
    apb(1'b0, 12'h004, 32'h0);
    chk("stack kept", r, 32'h80000100);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped", e, 1);
    // Every class once, interrupt stack flag alternating
    for (int c = 0; c < 8; c++)
      trap(2'h0, c[2:0], c[7:0] + 8'h11, 1'b0, 1'b0, 1'b0, c[0]);
    trap(2'h0, 3'h7, 8'h00, 1'b1, 1'b0, 1'b0, 1'b1);
    trap(2'h1, 3'h0, 8'hff, 1'b0, 1'b0, 1'b0, 1'b0);
    trap(2'h1, 3'h2, 8'h00, 1'b0, 1'b0, 1'b0, 1'b1);
    trap(2'h2, 3'h0, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0);
    trap(2'h3, 3'h0, 8'h00, 1'b0, 1'b0, 1'b0, 1'b1);
    trap(2'h0, 3'h3, 8'h01, 1'b0, 1'b0, 1'b1, 1'b0);
    trap(2'h0, 3'h3, 8'h04, 1'b0, 1'b1, 1'b0, 1'b0);
    // Last trap was an underflow in class 3, ident 4
    apb(1'b0, 12'h008, 32'h0);
    chk("status", r, 32'h00001304);
    apb(1'b0, 12'h00c, 32'h0);
    chk("last return", r, 32'h00004440);
    apb(1'b0, 12'h010, 32'h0);
    chk("last entry", r, 32'h00001060);
    stop_test;
  end
endmodule // tb
bind tte_trap_entry tte_chk tte_chk_inst (.*);
`default_nettype wire
